// >>> bench/asc_analog_src.sv
// behavioural analog pins behind the sample-and-hold
`timescale 1ns/1ps
`default_nettype none
module asc_analog_src (
  input wire logic clk_i,
  input wire logic sample_i,
  input wire logic vext_i,
  input wire logic [3:0] chan_i,
  input wire logic [9:0] code_i,
  output logic cmp_o
);
  int lvl[16];
  int held = 0;
  // hold selected pin, external reference at twice the rail
  always @(posedge clk_i) if (sample_i) held <= vext_i ? lvl[chan_i] >> 1 : lvl[chan_i];
  assign cmp_o = held >= code_i;
endmodule : asc_analog_src
`default_nettype wire

// >>> bench/asc_assertions.sv
// port checks for the converter sequencing control
`timescale 1ns/1ps
`default_nettype none
module asc_assertions (
  input wire logic clk_i, rst_i, cyc_i, stb_i, ack_o, sleep_i,
  input wire logic irq_o, wake_o, vref_ext_o,
  input wire logic [asc_pkg::CHS_W-1:0] channel_sel_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  chk_ack_answer: assert property (s_req |=> ack_o) else $error("no ack");
  chk_ack_single: assert property (ack_o |=> !ack_o) else $error("long ack");
  chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
  chk_wake_sleep: assert property (wake_o |-> $past(sleep_i) || $past(sleep_i, 2))
    else $error("wake while awake");
  chk_wake_irq: assert property (wake_o |-> irq_o || $past(irq_o))
    else $error("wake without irq");
  chk_chan_write: assert property ($changed(channel_sel_o) |-> ack_o || $past(ack_o))
    else $error("channel moved");
  chk_vref_write: assert property ($changed(vref_ext_o) |-> ack_o || $past(ack_o))
    else $error("reference moved");
  chk_irq_drop: assert property ($fell(irq_o) |-> ack_o)
    else $error("irq dropped");
endmodule : asc_assertions
bind asc_top asc_assertions u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .sleep_i,
  .irq_o, .wake_o, .vref_ext_o, .channel_sel_o);
`default_nettype wire

// >>> bench/tb_adc_sequencing_control.sv
// self-checking bench for the converter sequencing control
`timescale 1ns/1ps
`default_nettype none
module tb_adc_sequencing_control;
  import asc_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sleep_i = 0;
  logic [3:0] adr_i = 0, sel_i = 4'hF, channel_sel_o;
  logic [31:0] dat_i = 0, dat_o, rd, ctl;
  logic ack_o, cmp_i, sample_o, vref_ext_o, irq_o, wake_o;
  logic [9:0] dac_code_o;
  int fails = 0, cmp_count = 0, cyc, div, lvl, c, v, ie;
  int divs[4] = '{2, 8, 32, 64};
  asc_top DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .sleep_i, .cmp_i, .channel_sel_o, .sample_o, .vref_ext_o, .dac_code_o,
    .irq_o, .wake_o);
  asc_analog_src src (.clk_i, .sample_i(sample_o), .vext_i(vref_ext_o),
    .chan_i(channel_sel_o), .code_i(dac_code_o), .cmp_o(cmp_i));
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
  endtask : wb
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    close_out();
  end
  initial begin
    void'($urandom(69278));
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    wb(1, ADDR_CTRL, 32'h3);
    wb(0, ADDR_STAT, 0);
    chk("go_with_on", 0, rd[1]);
    for (int k = 0; k < 4; k++) begin
      c = $urandom % 16;
      v = $urandom % 2;
      ie = $urandom % 2;
      lvl = $urandom % 1024;
      sleep_i <= $urandom % 2;
      // pin taken as analog input before converting
      src.lvl[c] = lvl;
      ctl = 32'h801 | (ie << 10) | (k << 8) | (v << 6) | (c << 2);
      wb(1, ADDR_CTRL, ctl);
      repeat (8) @(posedge clk_i);
      chk("chan", c, channel_sel_o);
      chk("vref", v, vref_ext_o);
      wb(1, ADDR_CTRL, ctl | 32'h2);
      cyc = 0;
      do begin
        wb(0, ADDR_STAT, 0);
        cyc += 3;
      end while (rd[0] !== 1'b1);
      div = 11 * divs[k];
      chk("length", 1, cyc >= div - 3 && cyc <= div + 6);
      chk("irq", ie, irq_o);
      chk("wake", ie & sleep_i, wake_o);
      lvl = v ? lvl >> 1 : lvl;
      wb(0, ADDR_CTRL, 0);
      chk("go", 0, rd[1]);
      wb(0, ADDR_RES_LO, 0);
      chk("low", lvl[7:0], rd[7:0]);
      wb(0, ADDR_RES_HI, 0);
      chk("high", lvl[9:8], rd[7:0]);
      wb(1, ADDR_STAT, 1);
      wb(0, ADDR_STAT, 0);
      chk("clear", 0, rd[0]);
      $display("conversion %0d finished", k);
    end
    wb(0, 4'h2, 0);
    chk("unmapped", 0, rd);
    close_out();
  end
endmodule : tb_adc_sequencing_control
`default_nettype wire

// >>> rtl/asc_pkg.sv
// package of constants for the converter sequencing control
package asc_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RES_LO = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_RES_HI = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 4'hC;
  // control register fields
  localparam int unsigned CTRL_ON = 0;
  localparam int unsigned CTRL_GO = 1;
  localparam int unsigned CTRL_CHS_LSB = 2;
  localparam int unsigned CHS_W = 4;
  localparam int unsigned CTRL_VREF = 6;
  localparam int unsigned CTRL_CLKSEL_LSB = 8;
  localparam int unsigned CTRL_IE = 10;
  localparam int unsigned CTRL_RJUST = 11;
  // status register fields
  localparam int unsigned STAT_DONE = 0;
  localparam int unsigned STAT_BUSY = 1;
  localparam int unsigned RES_W = 10;
  localparam int unsigned BITS_PER_CONV = 11;
  // bit-period dividers in system clocks, selected by the clock select field
  localparam logic [7:0] DIV_SEL0 = 8'h02;
  localparam logic [7:0] DIV_SEL1 = 8'h08;
  localparam logic [7:0] DIV_SEL2 = 8'h20;
  localparam logic [7:0] DIV_SEL3 = 8'h40;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
endpackage : asc_pkg

// >>> rtl/asc_top.sv
// converter sequencing control with classic wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module asc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [asc_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic sleep_i,
  input wire logic cmp_i,
  output logic [asc_pkg::CHS_W-1:0] channel_sel_o,
  output logic sample_o,
  output logic vref_ext_o,
  output logic [asc_pkg::RES_W-1:0] dac_code_o,
  output logic irq_o,
  output logic wake_o
);
  import asc_pkg::*;

  typedef enum {ST_IDLE, ST_SAMPLE, ST_CONV} asc_state_t;

  typedef struct packed {
    logic [31:0] ctrl_reg;
    logic done_reg;
    logic [RES_W-1:0] result_reg;
    logic [RES_W-1:0] sar_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] div_cnt_reg;
    asc_state_t st_reg;
    logic [31:0] dat_reg;
    logic ack_reg;
    logic irq_reg;
    logic wake_reg;
    logic [CHS_W-1:0] chs_reg;
    logic sample_reg;
    logic vref_reg;
    logic [RES_W-1:0] dac_reg;
  } asc_s_t;

  asc_s_t s_reg;
  asc_s_t s_next;
  logic [7:0] div_max;
  logic tick;
  logic [RES_W-1:0] trial;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] wval;

  always_comb begin
    case (s_reg.ctrl_reg[CTRL_CLKSEL_LSB +: 2])
      2'h0: div_max = DIV_SEL0;
      2'h1: div_max = DIV_SEL1;
      2'h2: div_max = DIV_SEL2;
      default: div_max = DIV_SEL3;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    tick = (s_reg.div_cnt_reg == div_max - 8'h01);
    trial = s_reg.sar_reg | (10'h200 >> s_reg.bit_cnt_reg);
    wr = cyc_i && stb_i && we_i && !s_reg.ack_reg;
    wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wval = (s_reg.ctrl_reg & ~wmask) | (dat_i & wmask);
    s_next.ack_reg = cyc_i && stb_i && !s_reg.ack_reg;
    s_next.dat_reg = 32'h0000_0000;
    s_next.div_cnt_reg = tick ? 8'h00 : s_reg.div_cnt_reg + 8'h01;
    if (cyc_i && stb_i && !we_i && !s_reg.ack_reg) begin
      case (adr_i)
        ADDR_CTRL: s_next.dat_reg = s_reg.ctrl_reg;
        ADDR_RES_LO: s_next.dat_reg = s_reg.ctrl_reg[CTRL_RJUST] ?
          {24'h0, s_reg.result_reg[7:0]} : {24'h0, s_reg.result_reg[1:0], 6'h00};
        ADDR_RES_HI: s_next.dat_reg = s_reg.ctrl_reg[CTRL_RJUST] ?
          {30'h0, s_reg.result_reg[9:8]} : {24'h0, s_reg.result_reg[9:2]};
        ADDR_STAT: s_next.dat_reg = {30'h0, s_reg.st_reg != ST_IDLE, s_reg.done_reg};
        default: s_next.dat_reg = 32'h0000_0000;
      endcase
    end
    if (wr && adr_i == ADDR_CTRL) begin
      s_next.ctrl_reg = wval;
      if (!s_reg.ctrl_reg[CTRL_ON] || !wval[CTRL_ON]) begin
        s_next.ctrl_reg[CTRL_GO] = 1'b0;
      end
    end
    if (wr && adr_i == ADDR_STAT && sel_i[0] && dat_i[STAT_DONE]) begin
      s_next.done_reg = 1'b0;
    end
    case (s_reg.st_reg)
      ST_IDLE: begin
        if (s_reg.ctrl_reg[CTRL_GO] && s_reg.ctrl_reg[CTRL_ON]) begin
          s_next.st_reg = ST_SAMPLE;
          s_next.div_cnt_reg = 8'h00;
        end
      end
      ST_SAMPLE: begin
        if (tick) begin
          s_next.st_reg = ST_CONV;
          s_next.sar_reg = '0;
          s_next.bit_cnt_reg = 4'h0;
        end
      end
      ST_CONV: begin
        if (tick) begin
          if (s_reg.bit_cnt_reg < 4'(RES_W)) begin
            s_next.sar_reg = cmp_i ? trial : s_reg.sar_reg;
            s_next.bit_cnt_reg = s_reg.bit_cnt_reg + 4'h1;
          end
          if (s_reg.bit_cnt_reg == 4'(BITS_PER_CONV - 2)) begin
            s_next.st_reg = ST_IDLE;
            s_next.result_reg = cmp_i ? trial : s_reg.sar_reg;
            s_next.ctrl_reg[CTRL_GO] = 1'b0;
            s_next.done_reg = 1'b1;
          end
        end
      end
      default: s_next.st_reg = ST_IDLE;
    endcase
    // software dropping the on bit aborts
    if (!s_next.ctrl_reg[CTRL_ON]) begin
      s_next.st_reg = ST_IDLE;
      s_next.ctrl_reg[CTRL_GO] = 1'b0;
    end
    s_next.irq_reg = s_next.done_reg && s_next.ctrl_reg[CTRL_IE];
    s_next.wake_reg = s_next.done_reg && s_next.ctrl_reg[CTRL_IE] && sleep_i;
    s_next.chs_reg = s_next.ctrl_reg[CTRL_CHS_LSB +: CHS_W];
    s_next.sample_reg = s_next.ctrl_reg[CTRL_ON] && s_next.st_reg != ST_CONV;
    s_next.vref_reg = s_next.ctrl_reg[CTRL_VREF];
    s_next.dac_reg = s_next.sar_reg | (10'h200 >> s_next.bit_cnt_reg);
    if (rst_i) begin
      s_next = '0;
      s_next.ctrl_reg = CTRL_RESET;
      s_next.st_reg = ST_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end

  assign dat_o = s_reg.dat_reg;
  assign ack_o = s_reg.ack_reg;
  assign irq_o = s_reg.irq_reg;
  assign wake_o = s_reg.wake_reg;
  assign channel_sel_o = s_reg.chs_reg;
  assign sample_o = s_reg.sample_reg;
  assign vref_ext_o = s_reg.vref_reg;
  assign dac_code_o = s_reg.dac_reg;
endmodule : asc_top
`default_nettype wire
